// File: src/pfh_pkg.sv
// package for the parallel flash host controller: constants and carriers
// assumes a 100 MHz mclk and a byte-wide flash with active-low strobes
package pfh_pkg;

	// ------------------------------------------------------------
	// geometry
	// ------------------------------------------------------------
	localparam int ADDR_W    = 15;
	localparam int PAGE_BYTES = 64;
	localparam int BYTE_W    = 6;
	localparam int POLL_BIT  = 7;
	localparam int ALT_BIT   = 6;

	// ------------------------------------------------------------
	// timing, cycles of a 10 ns mclk
	// ------------------------------------------------------------
	localparam int CLK_NS        = 10;
	localparam int PULSE_NS      = 90;   // least write pulse, well above the filter
	localparam int PULSE_HIGH_NS = 100;  // least strobe high between loads
	localparam int READ_NS       = 250;  // slowest grade access time
	localparam int LOAD_GAP_US   = 150;  // longest gap between byte loads
	localparam int POWER_UP_US   = 5000; // power-on program lockout
	localparam int PROG_US       = 10000;
	localparam int PULSE_CYC  = (PULSE_NS + CLK_NS - 1) / CLK_NS;
	localparam int HIGH_CYC   = (PULSE_HIGH_NS + CLK_NS - 1) / CLK_NS;
	localparam int READ_CYC   = (READ_NS + CLK_NS - 1) / CLK_NS + 2;
	localparam int GAP_CYC    = LOAD_GAP_US * 1000 / CLK_NS;
	localparam int POWER_CYC  = POWER_UP_US * 1000 / CLK_NS;
	localparam int PROG_CYC   = PROG_US * 1000 / CLK_NS;
	localparam int TMR_W      = 24;

	// six-byte chip erase codes, address then data
	localparam logic [ADDR_W-1:0] ERASE_ADDR [6] = '{15'h5555, 15'h2aaa, 15'h5555,
		15'h5555, 15'h2aaa, 15'h5555};
	localparam logic [7:0] ERASE_DATA [6] = '{8'haa, 8'h55, 8'h80, 8'haa, 8'h55, 8'h10};

	// reset values of the pins
	localparam logic STROBE_IDLE = 1'b1;

	// ------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		PFH_OP_READ  = 2'b00,
		PFH_OP_WRITE = 2'b01,
		PFH_OP_ERASE = 2'b10,
		PFH_OP_ID    = 2'b11
	} pfh_op_t;

	typedef struct packed {
		pfh_op_t             op;
		logic [ADDR_W-1:0]   addr;
		logic [7:0]          data;
		logic                last;  // closes the page after this byte
	} pfh_req_t;

	typedef struct packed {
		logic                ce_n;
		logic                oe_n;
		logic                we_n;
		logic                hv_oe;  // output enable raised to erase level
		logic                hv_id;  // id trigger line raised to high level
		logic [ADDR_W-1:0]   addr;
		logic [7:0]          dout;
		logic                doe;
	} pfh_pins_t;

endpackage : pfh_pkg

// File: src/pfh_sync.sv
// two flip-flop synchroniser for the byte coming back from the flash
// assumes the flash data pins are asynchronous to mclk
`timescale 1ns/1ns
module pfh_sync #(
	parameter int W = 8
) (
	input  wire logic         mclk,
	input  wire logic         nrst,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_reg;
	logic [W-1:0] q_reg;

	// ------------------------------------------------------------
	// first stage feeds only the second
	// ------------------------------------------------------------
	always_ff @(posedge mclk or negedge nrst)
		if (!nrst)
		begin
			meta_reg <= '0;
			q_reg    <= '0;
		end
		else
		begin
			meta_reg <= d;
			q_reg    <= meta_reg;
		end

	assign q = q_reg;
endmodule : pfh_sync

// File: src/pfh_host.sv
// host controller that drives a byte-wide parallel flash through its pins
// assumes one request at a time on req_valid/req_ready, pins sampled via pfh_sync
`timescale 1ns/1ns
module pfh_host #(
	parameter int POWER_WAIT = pfh_pkg::POWER_CYC,
	parameter int LOAD_GAP   = pfh_pkg::GAP_CYC,
	parameter int PROG_MAX   = pfh_pkg::PROG_CYC
) (
	input  wire logic              mclk,
	input  wire logic              nrst,
	input  wire logic              req_valid,
	input  wire pfh_pkg::pfh_req_t req,
	output logic                   req_ready,
	output logic                   rsp_valid,
	output logic [7:0]             rsp_data,
	output logic                   rsp_timeout,
	output logic                   flash_ce_n,
	output logic                   flash_oe_n,
	output logic                   flash_we_n,
	output logic                   flash_hv_oe,
	output logic                   flash_hv_id,
	output logic [pfh_pkg::ADDR_W-1:0] flash_addr,
	output logic [7:0]             flash_dq_o,
	output logic                   flash_dq_oe,
	input  wire logic [7:0]        flash_dq_i
);
	import pfh_pkg::*;

	typedef enum logic [3:0] {
		ST_POWER = 4'b0000,
		ST_IDLE  = 4'b0001,
		ST_WLOW  = 4'b0010,
		ST_WHIGH = 4'b0011,
		ST_GAP   = 4'b0100,
		ST_RLOW  = 4'b0101,
		ST_RHIGH = 4'b0110,
		ST_POLL  = 4'b0111,
		ST_HVERA = 4'b1000,
		ST_DONE  = 4'b1001
	} pfh_state_t;

	pfh_state_t         state_reg, state_next;
	pfh_pins_t          pins_reg, pins_next;
	logic [TMR_W-1:0]   tmr_reg, tmr_next;      // phase timer
	logic [TMR_W-1:0]   busy_reg, busy_next;    // program watchdog
	logic [7:0]         last_reg, last_next;    // last byte loaded
	logic [7:0]         prev_reg, prev_next;    // previous poll read
	logic               first_reg, first_next;  // first poll read pending
	logic [2:0]         seq_reg, seq_next;      // erase code index
	logic               erase_reg, erase_next;
	logic               rd_op_reg, rd_op_next;  // chip erase codes going out
	logic               ready_reg, ready_next;
	logic               rv_reg, rv_next;
	logic               to_reg, to_next;
	logic [7:0]         rd_reg, rd_next;
	logic [7:0]         dq_s;

	// flash data returns asynchronously, so it is synchronised first
	pfh_sync #(.W(8)) u_sync (
		.mclk (mclk),
		.nrst (nrst),
		.d    (flash_dq_i),
		.q    (dq_s)
	);

	// ------------------------------------------------------------
	// next-state logic for pins and sequencing
	// ------------------------------------------------------------
	always_comb
	begin
		state_next = state_reg;
		pins_next  = pins_reg;
		tmr_next   = tmr_reg + TMR_W'(1);
		busy_next  = busy_reg;
		last_next  = last_reg;
		prev_next  = prev_reg;
		first_next = first_reg;
		seq_next   = seq_reg;
		erase_next = erase_reg;
		rd_op_next = rd_op_reg;
		ready_next = 1'b0;
		rv_next    = 1'b0;
		to_next    = 1'b0;
		rd_next    = rd_reg;
		case (state_reg)
			// no program attempt before the power-on lockout ends
			ST_POWER:
				if (tmr_reg >= TMR_W'(POWER_WAIT))
				begin
					state_next = ST_IDLE;
					ready_next = 1'b1;
				end
			ST_IDLE:
			begin
				ready_next = 1'b1;
				tmr_next   = '0;
				// select high with strobes high parks the flash in standby
				pins_next.ce_n = STROBE_IDLE;
				pins_next.doe  = 1'b0;
				if (req_valid && ready_reg)
				begin
					ready_next       = 1'b0;
					pins_next.addr   = req.addr;
					pins_next.hv_id  = 1'b0;
					case (req.op)
						PFH_OP_WRITE:
						begin
							// oe high before we falls; address valid on that edge
							pins_next.ce_n = 1'b0;
							pins_next.oe_n = 1'b1;
							pins_next.we_n = 1'b0;
							pins_next.dout = req.data;
							pins_next.doe  = 1'b1;
							last_next      = req.data;
							erase_next     = req.last;
							state_next     = ST_WLOW;
						end
						PFH_OP_ERASE:
						begin
							seq_next       = '0;
							pins_next.addr = ERASE_ADDR[0];
							pins_next.dout = ERASE_DATA[0];
							pins_next.ce_n = 1'b0;
							pins_next.oe_n = 1'b1;
							pins_next.we_n = 1'b0;
							pins_next.doe  = 1'b1;
							last_next      = 8'hff;
							erase_next     = 1'b1;
							rd_op_next     = 1'b1;   // only a real erase walks the codes
							state_next     = ST_WLOW;
						end
						PFH_OP_ID:
						begin
							pins_next.ce_n  = 1'b0;
							pins_next.oe_n  = 1'b0;
							pins_next.hv_id = 1'b1;
							pins_next.addr  = {{(ADDR_W-1){1'b0}}, req.addr[0]};
							state_next      = ST_RLOW;
						end
						default:
						begin
							pins_next.ce_n = 1'b0;
							pins_next.oe_n = 1'b0;
							state_next     = ST_RLOW;
						end
					endcase
				end
			end
			// hold the write pulse well past the glitch filter
			ST_WLOW:
				if (tmr_reg >= TMR_W'(PULSE_CYC - 1))
				begin
					pins_next.we_n = 1'b1;
					pins_next.ce_n = 1'b1;
					tmr_next       = '0;
					state_next     = ST_WHIGH;
				end
			ST_WHIGH:
				if (tmr_reg >= TMR_W'(HIGH_CYC - 1))
				begin
					pins_next.doe = 1'b0;
					tmr_next      = '0;
					// a page byte that happens to match the first code must not start erase
					if ((seq_reg != 3'd0 && seq_reg < 3'd5) || (rd_op_reg && seq_reg == 3'd0))
					begin
						// next erase code byte follows at once
						seq_next       = seq_reg + 3'd1;
						pins_next.addr = ERASE_ADDR[seq_reg + 3'd1];
						pins_next.dout = ERASE_DATA[seq_reg + 3'd1];
						pins_next.ce_n = 1'b0;
						pins_next.we_n = 1'b0;
						pins_next.doe  = 1'b1;
						state_next     = ST_WLOW;
					end
					else if (erase_reg)
						state_next = ST_GAP;
					else
					begin
						// page stays open: host sends the next byte quickly
						ready_next = 1'b1;
						state_next = ST_GAP;
					end
				end
			// load window; each next load must arrive before the gap expires
			ST_GAP:
			begin
				ready_next = !erase_reg;
				if (req_valid && ready_reg && req.op == PFH_OP_WRITE)
				begin
					ready_next     = 1'b0;
					pins_next.addr = req.addr;
					pins_next.dout = req.data;
					pins_next.ce_n = 1'b0;
					pins_next.we_n = 1'b0;
					pins_next.doe  = 1'b1;
					last_next      = req.data;
					erase_next     = req.last;
					tmr_next       = '0;
					state_next     = ST_WLOW;
				end
				else if (erase_reg || tmr_reg >= TMR_W'(LOAD_GAP - 1))
				begin
					// window closed: internal programming runs; unloaded bytes go to ff
					ready_next = 1'b0;
					busy_next  = '0;
					first_next = 1'b1;
					seq_next   = '0;
					tmr_next   = '0;
					state_next = ST_POLL;
				end
			end
			ST_RLOW:
				if (tmr_reg >= TMR_W'(READ_CYC))
				begin
					rd_next        = dq_s;
					pins_next.ce_n = 1'b1;
					pins_next.oe_n = 1'b1;
					pins_next.hv_id = 1'b0;
					rv_next        = 1'b1;
					tmr_next       = '0;
					state_next     = ST_DONE;
				end
			// poll by repeated reads until bit 7 true and bit 6 steady
			ST_POLL:
			begin
				busy_next = busy_reg + TMR_W'(1);
				if (tmr_reg == TMR_W'(1))
				begin
					pins_next.ce_n = 1'b0;
					pins_next.oe_n = 1'b0;
				end
				else if (tmr_reg == TMR_W'(READ_CYC))
				begin
					pins_next.ce_n = 1'b1;
					pins_next.oe_n = 1'b1;   // oe toggles each read, toggling the status bit
					prev_next      = dq_s;
					first_next     = 1'b0;
					if (!first_reg && dq_s[POLL_BIT] == last_reg[POLL_BIT]
						&& dq_s[ALT_BIT] == prev_reg[ALT_BIT])
					begin
						rd_next    = dq_s;
						rv_next    = 1'b1;
						state_next = ST_DONE;
					end
				end
				else if (tmr_reg >= TMR_W'(READ_CYC + HIGH_CYC))
					tmr_next = '0;
				// a stuck busy is reported rather than hanging the host
				if (busy_reg >= TMR_W'(PROG_MAX + PROG_MAX))
				begin
					to_next    = 1'b1;
					rv_next    = 1'b1;
					rd_next    = dq_s;
					pins_next.ce_n = 1'b1;
					pins_next.oe_n = 1'b1;
					state_next = ST_DONE;
				end
			end
			ST_HVERA:
				state_next = ST_DONE;
			ST_DONE:
			begin
				erase_next = 1'b0;
				rd_op_next = 1'b0;
				ready_next = 1'b1;
				state_next = ST_IDLE;
			end
			default:
				state_next = ST_IDLE;
		endcase
		// high voltage erase is not issued by this controller; pin parked low
		pins_next.hv_oe = 1'b0;
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge mclk or negedge nrst)
		if (!nrst)
		begin
			state_reg <= ST_POWER;
			pins_reg  <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, hv_oe: 1'b0, hv_id: 1'b0,
				addr: '0, dout: 8'h00, doe: 1'b0};
			tmr_reg   <= '0;
			busy_reg  <= '0;
			last_reg  <= 8'h00;
			prev_reg  <= 8'h00;
			first_reg <= 1'b0;
			seq_reg   <= 3'd0;
			erase_reg <= 1'b0;
			rd_op_reg <= 1'b0;
			ready_reg <= 1'b0;
			rv_reg    <= 1'b0;
			to_reg    <= 1'b0;
			rd_reg    <= 8'h00;
		end
		else
		begin
			state_reg <= state_next;
			pins_reg  <= pins_next;
			tmr_reg   <= tmr_next;
			busy_reg  <= busy_next;
			last_reg  <= last_next;
			prev_reg  <= prev_next;
			first_reg <= first_next;
			seq_reg   <= seq_next;
			erase_reg <= erase_next;
			rd_op_reg <= rd_op_next;
			ready_reg <= ready_next;
			rv_reg    <= rv_next;
			to_reg    <= to_next;
			rd_reg    <= rd_next;
		end

	assign req_ready   = ready_reg;
	assign rsp_valid   = rv_reg;
	assign rsp_data    = rd_reg;
	assign rsp_timeout = to_reg;
	assign flash_ce_n  = pins_reg.ce_n;
	assign flash_oe_n  = pins_reg.oe_n;
	assign flash_we_n  = pins_reg.we_n;
	assign flash_hv_oe = pins_reg.hv_oe;
	assign flash_hv_id = pins_reg.hv_id;
	assign flash_addr  = pins_reg.addr;
	assign flash_dq_o  = pins_reg.dout;
	assign flash_dq_oe = pins_reg.doe;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	write_oe_high_a: assert property (@(posedge mclk) disable iff (!nrst)
		!flash_we_n |-> flash_oe_n && !flash_dq_oe == 1'b0)
		else $error("write strobe low while output enable low or data not driven");

	no_bus_fight_a: assert property (@(posedge mclk) disable iff (!nrst)
		!flash_oe_n |-> !flash_dq_oe && flash_we_n)
		else $error("host drives data during a read");

	pulse_width_a: assert property (@(posedge mclk) disable iff (!nrst)
		$fell(flash_we_n) |-> !flash_we_n [*8])
		else $error("write pulse shorter than filter margin");

	power_lock_a: assert property (@(posedge mclk) disable iff (!nrst)
		state_reg == ST_POWER |-> flash_we_n)
		else $error("write attempted during power-on lockout");

	data_latch_a: assert property (@(posedge mclk) disable iff (!nrst)
		$rose(flash_we_n) |-> flash_dq_oe && $stable(flash_dq_o))
		else $error("data changed at rising write strobe");

	addr_stable_a: assert property (@(posedge mclk) disable iff (!nrst)
		!flash_we_n && !$fell(flash_we_n) |-> $stable(flash_addr))
		else $error("address moved during write pulse");

	standby_float_a: assert property (@(posedge mclk) disable iff (!nrst)
		state_reg == ST_IDLE && flash_ce_n |-> !flash_dq_oe)
		else $error("data driven in standby");

	done_true_a: assert property (@(posedge mclk) disable iff (!nrst)
		rsp_valid && !rsp_timeout |-> ##1 state_reg == ST_IDLE)
		else $error("host did not return to idle after completion");
endmodule : pfh_host

// File: testbench/pfh_flash_model.sv
// behavioural byte-wide flash: page load, self-timed program, polling, id codes
// assumes registered host pins; mclk paces the timers, and the strobes, address and data are sampled on its fall
`timescale 1ns/1ns
module pfh_flash_model
	import pfh_pkg::*;
#(
	parameter int         POWER_T = 20,
	parameter int         GAP_T   = 100,
	parameter int         PROG_T  = 300,
	parameter logic [7:0] MAKER   = 8'h3c, // arbitrary value
	parameter logic [7:0] PART    = 8'h7e  // arbitrary value
) (
	input  wire logic              mclk,
	input  wire logic              ce_n,
	input  wire logic              oe_n,
	input  wire logic              we_n,
	input  wire logic              hv_id,
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic [7:0]        host_d,
	input  wire logic              host_oe,
	output logic      [7:0]        bus
);
	logic [7:0]            mem [2**ADDR_W];
	logic [7:0]            page [PAGE_BYTES];
	logic [PAGE_BYTES-1:0] filled = '0;
	logic [ADDR_W-1:0]     lat_a  = '0;
	logic [ADDR_W-1:0]     page_a = '0;
	logic [7:0]            last_d = 8'h00;
	logic [7:0]            out_q  = 8'h00;
	logic                  ld_q = 1'b0, rd_q = 1'b0, loading = 1'b0, busy = 1'b0;
	logic                  ers = 1'b0, tgl = 1'b0, drive = 1'b0;
	int                    pwr = 0, gap = 0, tmr = 0, seq = 0;
	wire                   ld    = !ce_n && !we_n && oe_n;
	wire                   rd_on = !ce_n && !oe_n && we_n;

	// a released bus shows the inverse of the last byte, never a held value
	assign bus = host_oe ? host_d : (drive ? out_q : ~out_q);

	initial
	begin
		for (int i = 0; i < 2**ADDR_W; i++) mem[i] = i[7:0] ^ 8'h5a;
	end

	// ------------------------------------------------------------
	// device behaviour
	// ------------------------------------------------------------
	// pulses that start and end between two mclk falls are never seen, which acts as the noise filter
	always @(negedge mclk)
	begin
		if (pwr < POWER_T) pwr++;
		if (ld && !ld_q) lat_a = addr;
		if (!ld && ld_q && pwr >= POWER_T && !busy)
		begin
			page[lat_a[5:0]] = host_d;
			filled[lat_a[5:0]] = 1'b1;
			page_a = lat_a;
			last_d = host_d;
			loading = 1'b1;
			gap = 0;
			if (lat_a == ERASE_ADDR[seq] && host_d == ERASE_DATA[seq]) seq++;
			else seq = (lat_a == ERASE_ADDR[0] && host_d == ERASE_DATA[0]) ? 1 : 0;
			if (seq == 6)
			begin
				{ers, busy, loading} = 3'b110;
				tmr = 0;
				seq = 0;
			end
		end
		// a read inside the window closes it at once, as the host has moved on
		else if (loading && (++gap >= GAP_T || (rd_on && !rd_q)))
		begin
			{ers, busy, loading} = 3'b010;
			tmr = 0;
		end
		if (busy && ++tmr >= PROG_T)
		begin
			busy = 1'b0;
			for (int i = 0; i < 2**ADDR_W; i++)
				if (ers || i[ADDR_W-1:6] == page_a[ADDR_W-1:6])
					mem[i] = (ers || !filled[i[5:0]]) ? 8'hff : page[i[5:0]];
			filled = '0;
		end
		if (rd_on && !rd_q)
		begin
			if (busy) out_q = {~last_d[7], tgl, last_d[5:0]};
			else if (hv_id) out_q = addr[0] ? PART : MAKER;
			else out_q = mem[addr];
			tgl = busy ? ~tgl : tgl;
		end
		drive = rd_on;
		ld_q = ld;
		rd_q = rd_on;
	end
endmodule : pfh_flash_model

// File: testbench/pfh_host_test.sv
// self-checking bench for the flash host controller against a flash model
// assumes the model's preset contents are the address low byte xor 5a
`timescale 1ns/1ns
module pfh_host_test;
	import pfh_pkg::*;
	localparam int         LIMIT = 12000;
	localparam logic [7:0] MAKER = 8'h3c; // arbitrary value
	localparam logic [7:0] PART  = 8'h7e; // arbitrary value
	logic              mclk = 1'b0;
	logic              nrst = 1'b0;
	logic              req_valid = 1'b0;
	pfh_req_t          req = '0;
	logic              req_ready, rsp_valid, rsp_timeout, ce_n, oe_n, we_n, hv_oe, hv_id, dq_oe;
	logic [7:0]        rsp_data, dq_o, dq_i;
	logic [ADDR_W-1:0] faddr;
	int                bad_count = 0, samples_checked = 0, cyc = 0;

	initial
	begin
		forever #5 mclk = ~mclk;
	end

	pfh_host #(.POWER_WAIT(50), .LOAD_GAP(200), .PROG_MAX(500)) uut (.mclk(mclk),
		.nrst(nrst), .req_valid(req_valid), .req(req), .req_ready(req_ready),
		.rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_timeout(rsp_timeout),
		.flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n), .flash_hv_oe(hv_oe),
		.flash_hv_id(hv_id), .flash_addr(faddr), .flash_dq_o(dq_o), .flash_dq_oe(dq_oe),
		.flash_dq_i(dq_i));
	pfh_flash_model #(.MAKER(MAKER), .PART(PART)) mdl (.mclk(mclk), .ce_n(ce_n),
		.oe_n(oe_n), .we_n(we_n), .hv_id(hv_id), .addr(faddr), .host_d(dq_o),
		.host_oe(dq_oe), .bus(dq_i));

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask : check

	task automatic end_sim();
		$display("checks=%0d mismatches=%0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : end_sim

	// pin hazards and the run limit, watched every cycle
	always @(posedge mclk)
	begin
		cyc <= cyc + 1;
		if (nrst && !ce_n && !we_n) check({7'h0, oe_n}, 8'h01);
		if (nrst && !oe_n) check({7'h0, dq_oe}, 8'h00);
		if (cyc == LIMIT)
		begin
			bad_count++;
			end_sim();
		end
	end

	// ------------------------------------------------------------
	// bus tasks
	// ------------------------------------------------------------
	// request held until the edge that samples ready high
	task automatic send(input pfh_op_t op, input logic [ADDR_W-1:0] a, input logic [7:0] d,
		input logic l);
		@(posedge mclk);
		req_valid <= 1'b1;
		req <= '{op: op, addr: a, data: d, last: l};
		@(posedge mclk);
		while (req_ready !== 1'b1) @(posedge mclk);
		req_valid <= 1'b0;
	endtask : send

	task automatic wait_rsp();
		@(posedge mclk);
		while (rsp_valid !== 1'b1) @(posedge mclk);
	endtask : wait_rsp

	task automatic read_exp(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
		send(PFH_OP_READ, a, 8'h00, 1'b0);
		wait_rsp();
		check(rsp_data, exp);
	endtask : read_exp

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_reset();
		repeat (2) @(posedge mclk);
		check({1'b0, hv_oe, hv_id, ce_n, oe_n, we_n, dq_oe, req_ready}, 8'h1c);
		nrst <= 1'b1;
		repeat (40) @(posedge mclk);
		check({7'h0, req_ready}, 8'h00);
		while (req_ready !== 1'b1) @(posedge mclk);
		$display("test reset done");
	endtask : t_reset

	task automatic t_read();
		read_exp(15'h0123, 8'h23 ^ 8'h5a);
		read_exp(15'h7fff, 8'hff ^ 8'h5a);
		$display("test read done");
	endtask : t_read

	// bytes loaded out of order, page closed by the last flag
	task automatic t_page();
		logic [5:0] offs [3] = '{6'd5, 6'd2, 6'd63};
		logic [7:0] vals [3] = '{8'h11, 8'h92, 8'hc7};
		for (int i = 0; i < 3; i++) send(PFH_OP_WRITE, {9'h009, offs[i]}, vals[i], i == 2);
		wait_rsp();
		check(rsp_data, 8'hc7);
		check({7'h0, rsp_timeout}, 8'h00);
		for (int i = 0; i < 3; i++) read_exp({9'h009, offs[i]}, vals[i]);
		read_exp(15'h0240, 8'hff);
		$display("test page done");
	endtask : t_page

	// single byte, page closed by the load gap running out
	task automatic t_gap();
		send(PFH_OP_WRITE, 15'h1010, 8'h3c, 1'b0);
		wait_rsp();
		check(rsp_data, 8'h3c);
		check({7'h0, rsp_timeout}, 8'h00);
		read_exp(15'h1010, 8'h3c);
		read_exp(15'h1011, 8'hff);
		$display("test gap done");
	endtask : t_gap

	task automatic t_id();
		for (int a = 0; a < 2; a++)
		begin
			send(PFH_OP_ID, a[ADDR_W-1:0], 8'h00, 1'b0);
			wait_rsp();
			check(rsp_data, a ? PART : MAKER);
		end
		check({6'h0, hv_oe, hv_id}, 8'h00);
		$display("test id done");
	endtask : t_id

	// a whole page of bytes, loaded back to back the ordinary way
	task automatic t_full();
		for (int i = 0; i < PAGE_BYTES; i++)
			send(PFH_OP_WRITE, {9'h0a0, i[5:0]}, i[7:0] ^ 8'ha5, i == PAGE_BYTES - 1);
		wait_rsp();
		check(rsp_data, 8'h3f ^ 8'ha5);
		check({7'h0, rsp_timeout}, 8'h00);
		read_exp({9'h0a0, 6'd0}, 8'ha5);
		read_exp({9'h0a0, 6'd33}, 8'h21 ^ 8'ha5);
		$display("test full page done");
	endtask : t_full

	task automatic t_erase();
		send(PFH_OP_ERASE, 15'h0000, 8'h00, 1'b0);
		wait_rsp();
		check(rsp_data, 8'hff);
		check({7'h0, rsp_timeout}, 8'h00);
		read_exp(15'h0123, 8'hff);
		read_exp(15'h1010, 8'hff);
		$display("test erase done");
	endtask : t_erase

	initial
	begin
		t_reset();
		t_read();
		t_page();
		t_gap();
		t_id();
		t_full();
		t_erase();
		end_sim();
	end
endmodule : pfh_host_test
